// *** src/circ_pkg.sv ***
// circ_pkg: types and constants for the contact input run control block
// assumes a single 100 MHz clock domain and an asynchronous active-low reset
package circ_pkg;

   // input function selection
   typedef enum logic [2:0] {
      CIRC_FN_OFF,
      CIRC_FN_RUN,
      CIRC_FN_SW_NO,
      CIRC_FN_SW_NC,
      CIRC_FN_REMOTE
   } circ_func_t;

   // signal type of a run/stop or remote-select input
   typedef enum logic {
      CIRC_LEVEL_TYPE,
      CIRC_PULSE_TYPE
   } circ_sigtype_t;

   // reaction to a confirmed external-switch fault
   typedef enum logic [1:0] {
      CIRC_ALM_STOP,
      CIRC_ALM_CONTINUE,
      CIRC_ALM_IGNORE
   } circ_alm_act_t;

   // configuration of one contact input
   typedef struct packed {
      circ_func_t func;
      circ_sigtype_t sigtype;
   } circ_in_cfg_t;

   // reset defaults: input 1 level run/stop, input 2 unused
   localparam circ_in_cfg_t CIRC_IN1_RST = '{CIRC_FN_RUN, CIRC_LEVEL_TYPE};
   localparam circ_in_cfg_t CIRC_IN2_RST = '{CIRC_FN_OFF, CIRC_LEVEL_TYPE};

   // tick base: 100 MHz clock, 1 ms tick
   localparam int CIRC_CLK_HZ = 100000000;
   localparam int CIRC_TICK_MS = 1;
   localparam int CIRC_TICK_CYC = CIRC_CLK_HZ / 1000 * CIRC_TICK_MS;
   // minimum hold the far side keeps on pulse inputs
   localparam int CIRC_PULSE_HOLD_MS = 300;
   // timer widths in ticks, and default timer values (zero seconds)
   localparam int CIRC_TMR_W = 20;
   localparam logic [CIRC_TMR_W-1:0] CIRC_DELAY_RST = 20'h00000;
   localparam logic [CIRC_TMR_W-1:0] CIRC_OPEN_RST = 20'h00000;

   // interrupt status bit positions
   localparam int CIRC_IRQ_ALARM = 0;
   localparam int CIRC_IRQ_STOP = 1;
   localparam int CIRC_IRQ_W = 2;

endpackage

// *** src/circ_core.sv ***
// circ_core: run/stop, remote-select and external-switch supervision
// assumes contact pins are asynchronous, config ports are clk-synchronous
`timescale 1ns/1ps
`default_nettype none
module circ_core
   import circ_pkg::*;
#(
   parameter int TICK_CYC = CIRC_TICK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // contact pins, high = contact closed
   input wire logic [1:0] contact_in,
   // configuration
   input wire circ_in_cfg_t in1_cfg,
   input wire circ_in_cfg_t in2_cfg,
   input wire logic [CIRC_TMR_W-1:0] read_delay_ticks,
   input wire logic [CIRC_TMR_W-1:0] open_detect_ticks,
   input wire circ_alm_act_t alarm_action,
   input wire logic ext_sw1_mode_ok,
   input wire logic ext_sw2_mode_ok,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // status outputs
   output logic running,
   output logic remote_mode,
   output logic input2_detection_alarm,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // register addresses
   localparam logic [1:0] ADDR_STATUS = 2'h0;
   localparam logic [1:0] ADDR_MASK = 2'h1;
   localparam logic [1:0] ADDR_STATE = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // two-stage sync
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] prev_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         prev_q <= 2'h0;
      end else begin
         sync1_q <= contact_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   logic [1:0] release_p;
   assign release_p = prev_q & ~sync2_q;

   ////////////////////////////////////////////////////////////////////////
   // fixed ms tick
   logic [26:0] tick_cnt_q;
   logic tick;
   assign tick = (tick_cnt_q == 27'(TICK_CYC - 1));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 27'h0000000;
      end else if (tick) begin
         tick_cnt_q <= 27'h0000000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 27'h0000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode which input carries which function
   circ_in_cfg_t cfg [2];
   assign cfg[0] = in1_cfg;
   assign cfg[1] = in2_cfg;

   logic run_lvl_req;
   logic run_toggle;
   logic rmt_lvl_any;
   logic rmt_lvl_req;
   logic rmt_toggle;
   logic [1:0] sw_en;
   logic [1:0] sw_open;

   always_comb begin
      run_lvl_req = 1'b0;
      run_toggle = 1'b0;
      rmt_lvl_any = 1'b0;
      rmt_lvl_req = 1'b0;
      rmt_toggle = 1'b0;
      sw_en = 2'h0;
      sw_open = 2'h0;
      for (int i = 0; i < 2; i++) begin
         case (cfg[i].func)
            CIRC_FN_RUN: begin
               if (cfg[i].sigtype == CIRC_LEVEL_TYPE) begin
                  run_lvl_req = run_lvl_req | sync2_q[i];
               // pulse toggle, relies on hold by far side
               end else begin
                  run_toggle = run_toggle | release_p[i];
               end
            end
            CIRC_FN_REMOTE: begin
               if (cfg[i].sigtype == CIRC_LEVEL_TYPE) begin
                  rmt_lvl_any = 1'b1;
                  rmt_lvl_req = rmt_lvl_req | sync2_q[i];
               end else begin
                  rmt_toggle = rmt_toggle | release_p[i];
               end
            end
            // polarity: open-type faults when contact opens
            CIRC_FN_SW_NO: begin
               sw_en[i] = 1'b1;
               sw_open[i] = ~sync2_q[i];
            end
            CIRC_FN_SW_NC: begin
               sw_en[i] = 1'b1;
               sw_open[i] = sync2_q[i];
            end
            default: begin
            end
         endcase
      end
   end

   // which input level-types run (so a level release stops)
   logic run_lvl_cfg;
   always_comb begin
      run_lvl_cfg = 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (cfg[i].func == CIRC_FN_RUN &&
             cfg[i].sigtype == CIRC_LEVEL_TYPE) begin
            run_lvl_cfg = 1'b1;
         end
      end
   end

   logic [1:0] sw_active;
   assign sw_active = sw_en & {ext_sw2_mode_ok, ext_sw1_mode_ok};

   ////////////////////////////////////////////////////////////////////////
   // supervision state machine
   typedef enum logic [1:0] {
      CIRC_ST_IDLE,
      CIRC_ST_DELAY,
      CIRC_ST_MONITOR
   } circ_sup_t;

   circ_sup_t sup_q;
   logic [CIRC_TMR_W-1:0] delay_cnt_q;
   logic [CIRC_TMR_W-1:0] open_cnt_q [2];
   logic [1:0] sw_fault;
   logic fault_any;
   logic stop_fault;

   // open confirmed once count reaches open time
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sw_fault[i] = sw_active[i] && sw_open[i] &&
                       (open_cnt_q[i] >= open_detect_ticks);
      end
   end

   assign fault_any = (sup_q == CIRC_ST_MONITOR) && (|sw_fault) &&
                      (alarm_action != CIRC_ALM_IGNORE);
   assign stop_fault = fault_any && (alarm_action == CIRC_ALM_STOP);
   // a latched stop alarm holds the stop; only a pulse start gets past
   logic stop_hold;
   assign stop_hold = input2_detection_alarm && !run_toggle &&
                      (alarm_action == CIRC_ALM_STOP);

   // run state; a fault stop wins over any start in the same cycle
   logic run_d;
   always_comb begin
      run_d = running;
      if (run_lvl_cfg) begin
         run_d = run_lvl_req;
      end else if (run_toggle) begin
         run_d = ~running;
      end
      if (stop_fault || stop_hold) begin
         run_d = 1'b0;
      end
   end

   // nothing assigned leaves run state alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         running <= 1'b0;
      end else begin
         running <= run_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sup_q <= CIRC_ST_IDLE;
         delay_cnt_q <= CIRC_DELAY_RST;
      end else if (!run_d) begin
         sup_q <= CIRC_ST_IDLE;
         delay_cnt_q <= CIRC_DELAY_RST;
      end else begin
         case (sup_q)
            CIRC_ST_IDLE: begin
               sup_q <= CIRC_ST_DELAY;
               delay_cnt_q <= CIRC_DELAY_RST;
            end
            CIRC_ST_DELAY: begin
               if (delay_cnt_q >= read_delay_ticks) begin
                  sup_q <= CIRC_ST_MONITOR;
               end else if (tick) begin
                  delay_cnt_q <= delay_cnt_q + 1'b1;
               end
            end
            CIRC_ST_MONITOR: begin
               sup_q <= CIRC_ST_MONITOR;
            end
            default: begin
               sup_q <= CIRC_ST_IDLE;
            end
         endcase
      end
   end

   // continuous open counters, saturating; a close restarts them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         open_cnt_q[0] <= CIRC_OPEN_RST;
         open_cnt_q[1] <= CIRC_OPEN_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sup_q != CIRC_ST_MONITOR || !sw_open[i]) begin
               open_cnt_q[i] <= CIRC_OPEN_RST;
            end else if (tick && open_cnt_q[i] != {CIRC_TMR_W{1'b1}}) begin
               open_cnt_q[i] <= open_cnt_q[i] + 1'b1;
            end
         end
      end
   end

   // alarm latch, held until the run input is released or pulsed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input2_detection_alarm <= 1'b0;
      end else if (fault_any) begin
         input2_detection_alarm <= 1'b1;
      end else if (run_toggle || (run_lvl_cfg && !run_lvl_req)) begin
         input2_detection_alarm <= 1'b0;
      end
   end

   // remote mode: level follows input, pulse toggles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remote_mode <= 1'b0;
      end else if (rmt_lvl_any) begin
         remote_mode <= rmt_lvl_req;
      end else if (rmt_toggle) begin
         remote_mode <= ~remote_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: set wins over write-one-to-clear
   logic [CIRC_IRQ_W-1:0] irq_stat_q;
   logic [CIRC_IRQ_W-1:0] irq_mask_q;
   logic [CIRC_IRQ_W-1:0] irq_set;
   assign irq_set[CIRC_IRQ_ALARM] = fault_any && !input2_detection_alarm;
   assign irq_set[CIRC_IRQ_STOP] = running && !run_d;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == ADDR_STATUS) ?
                       reg_wdata[CIRC_IRQ_W-1:0] : '0)) | irq_set;
      end
   end

   // mask register write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_q <= '0;
      end else if (reg_wr && reg_addr == ADDR_MASK) begin
         irq_mask_q <= reg_wdata[CIRC_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // read data one cycle after strobe; unmapped reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_STATUS: reg_rdata <= {6'h00, irq_stat_q};
            ADDR_MASK: reg_rdata <= {6'h00, irq_mask_q};
            ADDR_STATE: reg_rdata <= {3'h0, sup_q, input2_detection_alarm,
                                      remote_mode, running};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// *** verification/circ_chk.sv ***
// checker: port relations of the contact run control core
// assumes a bind into circ_core on its single clock
`timescale 1ns/1ps
`default_nettype none
module circ_chk
   import circ_pkg::*;
#(
   parameter int TICK_CYC = CIRC_TICK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins and setup
   input wire logic [1:0] contact_in,
   input wire circ_in_cfg_t in1_cfg,
   input wire circ_in_cfg_t in2_cfg,
   input wire logic [CIRC_TMR_W-1:0] read_delay_ticks,
   input wire logic [CIRC_TMR_W-1:0] open_detect_ticks,
   input wire circ_alm_act_t alarm_action,
   // status
   input wire logic running,
   input wire logic remote_mode,
   input wire logic input2_detection_alarm
);
   logic lvl1, pls1, rl2, idle;
   int run_q, lb;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // run decodes only with input 2 unused, so no alarm can interfere
   assign lvl1 = in1_cfg == CIRC_IN1_RST && in2_cfg == CIRC_IN2_RST;
   assign pls1 = in1_cfg.func == CIRC_FN_RUN && in2_cfg == CIRC_IN2_RST
      && in1_cfg.sigtype == CIRC_PULSE_TYPE;
   assign rl2 = in2_cfg.func == CIRC_FN_REMOTE
      && in2_cfg.sigtype == CIRC_LEVEL_TYPE;
   assign idle = in1_cfg.func != CIRC_FN_RUN && in2_cfg.func != CIRC_FN_RUN;
   // two ticks of slack: the tick runs free, so each timer may be short
   assign lb = int'(read_delay_ticks) + int'(open_detect_ticks) - 2;
   // cycles spent running since the last start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 0;
      end else begin
         run_q <= running ? run_q + 1 : 0;
      end
   end
   property p_lvl_on; (lvl1 && contact_in[0]) [*5] |-> running; endproperty
   a_lvl_on: assert property (p_lvl_on)
      else $error("level run held but stopped");
   property p_lvl_off; (lvl1 && !contact_in[0]) [*5] |-> !running; endproperty
   a_lvl_off: assert property (p_lvl_off)
      else $error("level run released but running");
   property p_idle; idle [*5] |-> !$rose(running); endproperty
   a_idle: assert property (p_idle)
      else $error("start without a run input");
   property p_pls; pls1 && $fell(contact_in[0]) |-> ##[2:4] $changed(running);
   endproperty
   a_pls: assert property (p_pls)
      else $error("pulse release did not toggle");
   property p_rmt;
      (rl2 && $stable(contact_in[1])) [*5] |-> remote_mode == contact_in[1];
   endproperty
   a_rmt: assert property (p_rmt)
      else $error("remote level not followed");
   property p_stop;
      $rose(input2_detection_alarm) && alarm_action == CIRC_ALM_STOP
         |=> !running;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop alarm left machine running");
   property p_live;
      $rose(input2_detection_alarm)
         |-> $past(running) && alarm_action != CIRC_ALM_IGNORE;
   endproperty
   a_live: assert property (p_live)
      else $error("alarm while stopped or ignored");
   property p_wait; $rose(input2_detection_alarm) |-> run_q >= lb * TICK_CYC;
   endproperty
   a_wait: assert property (p_wait)
      else $error("alarm before delay and open time");
   c_run: cover property ($rose(running));
   c_alm: cover property ($rose(input2_detection_alarm));
   c_rmt: cover property ($rose(remote_mode));
endmodule
bind circ_core circ_chk #(.TICK_CYC(TICK_CYC)) chk_u (
   .clk, .rst_n, .contact_in, .in1_cfg, .in2_cfg, .read_delay_ticks,
   .open_detect_ticks, .alarm_action, .running, .remote_mode,
   .input2_detection_alarm
);
`default_nettype wire

// *** verification/circ_far.sv ***
// far side: customer run, remote and switch contacts
// assumes one-cycle pulse requests on the design clock
`timescale 1ns/1ps
`default_nettype none
module circ_far #(
   parameter int HOLD_CYC = 3000
) (
   // clock
   input wire logic clk,
   // wanted levels and pulse requests
   input wire logic [1:0] lvl,
   input wire logic [1:0] pulse_go,
   // contact pins
   output logic [1:0] contact_in
);
   int cnt [2];
   // full pulse hold
   // a pulse stays closed for the whole hold before release
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         cnt[i] <= pulse_go[i] ? HOLD_CYC : (cnt[i] > 0 ? cnt[i] - 1 : 0);
      end
   end
   // pin closed by a level or a pulse in progress
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         contact_in[i] = lvl[i] | (cnt[i] > 0);
      end
   end
endmodule
`default_nettype wire

// *** verification/contact_input_run_control_tb.sv ***
// bench: contact run control core with a far-side contact model
// assumes circ_core, circ_far and the bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(gv, ev) begin compares++; if ((gv) !== (ev)) begin n_fail++; \
   $display("Error %0t got %h exp %h", $time, gv, ev); end end
module contact_input_run_control_tb
   import circ_pkg::*;
();
   localparam int TK = 10;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [1:0] lvl = 2'h0, pgo = 2'h0, mok = 2'h3, ra = 2'h0, pins;
   circ_in_cfg_t c1 = CIRC_IN1_RST, c2 = CIRC_IN2_RST;
   logic [CIRC_TMR_W-1:0] dly = '0, opn = '0;
   circ_alm_act_t act = CIRC_ALM_STOP;
   logic [7:0] wd = 8'h00, rdat;
   logic run, remote_select_input, alm, irq;
   int n_fail = 0, compares = 0;
   logic [31:0] seed = 32'h2A8C;
   // short tick keeps the timers brief
   circ_core #(.TICK_CYC(TK)) dut_u (.clk(clk), .rst_n(rst_n),
      .contact_in(pins), .in1_cfg(c1), .in2_cfg(c2), .read_delay_ticks(dly),
      .open_detect_ticks(opn), .alarm_action(act), .ext_sw1_mode_ok(mok[0]),
      .ext_sw2_mode_ok(mok[1]), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdat), .running(run), .remote_mode(remote_select_input),
      .input2_detection_alarm(alm), .irq(irq));
   circ_far #(.HOLD_CYC(CIRC_PULSE_HOLD_MS * TK)) far_u (.clk(clk),
      .lvl(lvl), .pulse_go(pgo), .contact_in(pins));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // switch pin: normally-open reads low when open, normally-closed high
   function automatic logic sw_lvl(input int nc, input logic open);
      return (nc != 0) ~^ open;
   endfunction
   // wait edges, then let updates land before sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdat;
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      pgo[i] <= 1'b1;
      @(posedge clk);
      pgo[i] <= 1'b0;
      cyc(CIRC_PULSE_HOLD_MS * TK + 6);
   endtask
   task automatic complete_run();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // watchdog well past the expected run length
   initial begin
      cyc(40000);
      n_fail++;
      complete_run();
   end
   initial begin
      logic [7:0] r;
      logic e;
      int j;
      cyc(12);
      rst_n <= 1'b1;
      cyc(2);
      `CHK(run, 1'b0)
      lvl <= 2'h1;
      cyc(6 + int'(xs() % 64));
      `CHK(run, 1'b1)
      rreg(2'h3, r);
      `CHK(r, 8'h00)
      // state word: monitoring, no alarm, panel control, running
      rreg(2'h2, r);
      `CHK(r, 8'h11)
      lvl <= 2'h0;
      cyc(6);
      `CHK(run, 1'b0)
      c1 <= '{CIRC_FN_RUN, CIRC_PULSE_TYPE};
      for (j = 0; j < 2; j++) begin
         pulse(0);
         `CHK(run, j == 0)
      end
      c1 <= CIRC_IN2_RST;
      lvl <= 2'h1;
      cyc(8);
      `CHK(run, 1'b0)
      lvl <= 2'h2;
      c2 <= '{CIRC_FN_REMOTE, CIRC_LEVEL_TYPE};
      cyc(6);
      `CHK(remote_select_input, 1'b1)
      lvl <= 2'h0;
      cyc(6);
      `CHK(remote_select_input, 1'b0)
      c2 <= '{CIRC_FN_REMOTE, CIRC_PULSE_TYPE};
      for (j = 0; j < 2; j++) begin
         pulse(1);
         `CHK(remote_select_input, j == 0)
      end
      // supervision: actions, polarity, mode gate (k 6), stop first (k 7)
      c1 <= CIRC_IN1_RST;
      for (int k = 0; k < 8; k++) begin
         e = k != 6 && k != 7 && k % 3 != 2;
         wreg(2'h1, {7'h00, k < 3});
         rreg(2'h1, r);
         `CHK(r, {7'h00, k < 3})
         act <= circ_alm_act_t'(k % 3);
         c2 <= '{(k % 2) ? CIRC_FN_SW_NC : CIRC_FN_SW_NO, CIRC_LEVEL_TYPE};
         dly <= CIRC_TMR_W'(xs() % 4);
         opn <= CIRC_TMR_W'(xs() % 4);
         mok <= {k != 6, 1'b1};
         lvl <= {sw_lvl(k % 2, k == 0), 1'b1};
         cyc(100);
         `CHK(alm, k == 0)
         if (k == 7) begin
            lvl[0] <= 1'b0;
            cyc(6);
         end
         lvl[1] <= sw_lvl(k % 2, 1'b1);
         for (j = 0; j < 80 && alm !== 1'b1; j++) begin
            cyc(1);
         end
         `CHK(k == 0 || j >= (int'(opn) - 1) * TK, 1'b1)
         cyc(2);
         `CHK(alm, e)
         `CHK(run, k != 7 && !(e && k % 3 == 0))
         `CHK(irq, e && k < 3)
         rreg(2'h0, r);
         `CHK(r[0], e)
         wreg(2'h0, 8'h03);
         cyc(1);
         `CHK(irq, 1'b0)
         lvl <= 2'h0;
         cyc(8);
      end
      complete_run();
   end
endmodule
`default_nettype wire
